//--- ebh_pkg.sv
// Shared constants and types for the external bus hold and reset pin block
package ebh_pkg;

   // Clock rate of this logic and the CPU cycle P, both in ns
   localparam int CLK_PERIOD_NS = 4;
   localparam int CPU_PERIOD_NS = 4;

   // Hold handshake times, in CPU cycles P
   localparam int HIZ_MIN_P = 4;
   localparam int GRANT_LOW_MAX_P = 2;
   localparam int GRANT_HIGH_MIN_P = 4;
   localparam int GRANT_HIGH_MAX_P = 7;
   localparam int DRIVE_MIN_P = 3;
   localparam int DRIVE_MAX_P = 6;

   // Least times round up, longest times round down
   localparam int HIZ_MIN_CYC =
      (HIZ_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GRANT_LOW_MAX_CYC =
      (GRANT_LOW_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;
   localparam int GRANT_HIGH_MIN_CYC =
      (GRANT_HIGH_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GRANT_HIGH_MAX_CYC =
      (GRANT_HIGH_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;
   localparam int DRIVE_MIN_CYC =
      (DRIVE_MIN_P * CPU_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DRIVE_MAX_CYC =
      (DRIVE_MAX_P * CPU_PERIOD_NS) / CLK_PERIOD_NS;

   // Request synchroniser depth and the retained SDRAM run length
   localparam int SYNC_STAGES = 2;
   localparam logic [3:0] BURST_RETAIN_LEN = 4'h8;

   // Reset width the reset source must give, in output clock cycles
   localparam int RESET_MIN_CYC = 10;

   // Register byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;

   // Control register fields and reset value
   localparam int CTRL_HOLD_DIS_BIT = 0;
   localparam int CTRL_RETAIN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Status register fields
   localparam int STAT_GRANT_BIT = 0;
   localparam int STAT_RELEASED_BIT = 1;
   localparam int STAT_REQ_BIT = 2;
   localparam int STAT_PENDING_BIT = 3;
   localparam int STAT_DRAIN_BIT = 4;

   // Idle levels of the memory port pins
   localparam logic [9:0] CTL_STROBE_IDLE = 10'h3ff;
   localparam logic [3:0] SELECT_IDLE = 4'hf;

   // Hold handshake states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DRAIN,
      ST_RELEASED,
      ST_HELD,
      ST_RESUME
   } ebh_state_t;

endpackage

//--- ebh_sync.sv
// Two-stage synchroniser for levels arriving without regard to clk
`timescale 1ns/1ns
module ebh_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] stage1_reg;

   // First stage is read only by the second stage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1_reg <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         stage1_reg <= d;
         q <= stage1_reg;
      end
   end

endmodule // ebh_sync

//--- ebh_top.sv
// Bus hold handshake, memory pin release and reset pin states
`timescale 1ns/1ns
module ebh_top
   import ebh_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Hold handshake with the outside master
   input wire logic busRequestN,
   output logic busGrantN,
   // Memory controller side
   input wire logic memXferBusy,
   input wire logic asyncAccessActive,
   input wire logic asyncReadyIn,
   input wire logic sdramAccess,
   input wire logic [31:0] ctlDataOut,
   input wire logic ctlDataOeN,
   input wire logic [19:0] ctlAddr,
   input wire logic [3:0] ctlChipEnableN,
   input wire logic [3:0] ctlByteEnableN,
   input wire logic [9:0] ctlStrobeN,
   output logic holdPending,
   output logic [31:0] memReadData,
   // Memory port pins
   input wire logic [31:0] extDataBusIn,
   output logic [31:0] extDataBusOut,
   output logic extDataBusOeN,
   output logic [19:0] extAddrBus,
   output logic [3:0] chipEnableN,
   output logic [3:0] byteEnableN,
   output logic [9:0] memStrobeN,
   output logic memBusOeN,
   // Other units' pin values
   input wire logic irqAckIn,
   input wire logic [3:0] irqNumberIn,
   input wire logic [3:0] dmaEventIn,
   input wire logic powerdownIn,
   input wire logic timerAIn,
   input wire logic timerBIn,
   input wire logic hostInterruptIn,
   input wire logic hostReadyInN,
   input wire logic hostSelectN,
   input wire logic [15:0] hostDataOutIn,
   input wire logic hostDataOeInN,
   input wire logic [9:0] serialPinsIn,
   input wire logic [9:0] serialOeInN,
   // Reset-sensitive pins
   output logic irqAckOut,
   output logic [3:0] irqNumberOut,
   output logic [3:0] dmaEventOut,
   output logic powerdownOut,
   output logic timerOutA,
   output logic timerOutB,
   output logic hostInterruptOut,
   output logic hostReadyN,
   output logic [15:0] hostDataBusOut,
   output logic hostDataBusOeN,
   output logic [9:0] serialPinsOut,
   output logic [9:0] serialPinsOeN
);

   ebh_state_t state_reg;
   logic [3:0] elapsed_reg;
   logic [3:0] sdramRun_reg;
   logic [1:0] ctrl_reg;
   logic reqSyncN;
   logic holdDisable;
   logic burstEightRetain;
   logic asyncStretch;
   logic retainWait;
   logic pendingClear;
   logic releaseNow;
   logic resumeNow;
   logic memBusOeNext;
   logic apWrite_reg;
   logic [7:0] apAddr_reg;
   logic accessTaken;
   logic [31:0] readValue;

   assign holdDisable = ctrl_reg[CTRL_HOLD_DIS_BIT];
   assign burstEightRetain = ctrl_reg[CTRL_RETAIN_BIT];

   // Request may change at any time, so it passes two flops
   ebh_sync #(
      .WIDTH(1),
      .RESET_VAL(1'h1)
   ) reqSync (
      .clk(clk),
      .reset_n(reset_n),
      .d(busRequestN),
      .q(reqSyncN)
   );

   // Length of the current run of back-to-back SDRAM accesses
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sdramRun_reg <= 4'h0;
      end else if (!sdramAccess) begin
         sdramRun_reg <= 4'h0;
      end else if (sdramRun_reg != 4'hf) begin
         sdramRun_reg <= sdramRun_reg + 4'h1;
      end
   end

   // Nothing may be cut short: a stalled async access or a retained
   // SDRAM run shorter than eight both hold off the release
   assign asyncStretch = asyncAccessActive && !asyncReadyIn;
   assign retainWait = burstEightRetain && sdramAccess &&
      (sdramRun_reg < BURST_RETAIN_LEN - 4'h1);
   assign pendingClear = !memXferBusy && !asyncStretch && !retainWait;

   // Release once four cycles have passed since the request fell
   assign releaseNow = (state_reg == ST_DRAIN) && !reqSyncN &&
      !holdDisable && pendingClear &&
      (elapsed_reg >= 4'(HIZ_MIN_CYC - 1));
   // Drive again three to six cycles after the request rose
   assign resumeNow = (state_reg == ST_RESUME) &&
      (elapsed_reg >= 4'(DRIVE_MIN_CYC - 1)) &&
      (elapsed_reg <= 4'(DRIVE_MAX_CYC - 1));

   // Next release state, shared by all released pins; outside a hold
   // the pins are driven, which also ends the high impedance of reset
   always_comb begin
      memBusOeNext = memBusOeN;
      if (releaseNow) begin
         memBusOeNext = 1'b1;
      end else if (resumeNow) begin
         memBusOeNext = 1'b0;
      end else if (state_reg == ST_IDLE || state_reg == ST_DRAIN) begin
         memBusOeNext = 1'b0;
      end
   end

   // Hold handshake sequence
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         elapsed_reg <= 4'h0;
         busGrantN <= 1'b1;
         holdPending <= 1'b0;
      end else begin
         if (elapsed_reg != 4'hf) begin
            elapsed_reg <= elapsed_reg + 4'h1;
         end
         case (state_reg)
            ST_IDLE: begin
               // Hold disable keeps the grant away while the bit is set
               if (!reqSyncN && !holdDisable) begin
                  state_reg <= ST_DRAIN;
                  holdPending <= 1'b1;
                  // Request fell two stages plus this edge ago
                  elapsed_reg <= 4'(SYNC_STAGES + 1);
               end
            end
            ST_DRAIN: begin
               if (reqSyncN || holdDisable) begin
                  state_reg <= ST_IDLE;
                  holdPending <= 1'b0;
               end else if (releaseNow) begin
                  state_reg <= ST_RELEASED;
               end
            end
            ST_RELEASED: begin
               // Grant one cycle after release, inside the limit
               if (GRANT_LOW_MAX_CYC >= 1) begin
                  busGrantN <= 1'b0;
               end
               state_reg <= ST_HELD;
            end
            ST_HELD: begin
               // Stay here as long as the request is held low
               if (reqSyncN) begin
                  state_reg <= ST_RESUME;
                  elapsed_reg <= 4'(SYNC_STAGES + 1);
               end
            end
            ST_RESUME: begin
               if (elapsed_reg >= 4'(GRANT_HIGH_MIN_CYC - 1) &&
                   elapsed_reg <= 4'(GRANT_HIGH_MAX_CYC - 1)) begin
                  busGrantN <= 1'b1;
                  holdPending <= 1'b0;
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Memory pin enables; reset acts at the next edge only
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         memBusOeN <= 1'b1;
         extDataBusOeN <= 1'b1;
      end else begin
         memBusOeN <= memBusOeNext;
         extDataBusOeN <= memBusOeNext || ctlDataOeN;
      end
   end

   // Memory pin values follow the controller; idle levels in reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         extDataBusOut <= 32'h0;
         extAddrBus <= 20'h0;
         chipEnableN <= SELECT_IDLE;
         byteEnableN <= SELECT_IDLE;
         memStrobeN <= CTL_STROBE_IDLE;
         memReadData <= 32'h0;
      end else begin
         extDataBusOut <= ctlDataOut;
         extAddrBus <= ctlAddr;
         chipEnableN <= ctlChipEnableN;
         byteEnableN <= ctlByteEnableN;
         memStrobeN <= ctlStrobeN;
         memReadData <= extDataBusIn;
      end
   end

   // Low group pins held low while reset is asserted
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irqAckOut <= 1'b0;
         irqNumberOut <= 4'h0;
         dmaEventOut <= 4'h0;
         powerdownOut <= 1'b0;
         timerOutA <= 1'b0;
         timerOutB <= 1'b0;
      end else begin
         irqAckOut <= irqAckIn;
         irqNumberOut <= irqNumberIn;
         dmaEventOut <= dmaEventIn;
         powerdownOut <= powerdownIn;
         timerOutA <= timerAIn;
         timerOutB <= timerBIn;
      end
   end

   // High group, host ready and the host and serial Z group
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hostInterruptOut <= 1'b1;
         // Ready is gated by select, tracked through the reset
         hostReadyN <= ~hostSelectN;
         hostDataBusOut <= 16'h0;
         hostDataBusOeN <= 1'b1;
         serialPinsOut <= 10'h0;
         serialPinsOeN <= 10'h3ff;
      end else begin
         hostInterruptOut <= hostInterruptIn;
         hostReadyN <= hostReadyInN;
         hostDataBusOut <= hostDataOutIn;
         hostDataBusOeN <= hostDataOeInN;
         serialPinsOut <= serialPinsIn;
         serialPinsOeN <= serialOeInN;
      end
   end

   // AHB-Lite address phase taken on any selected NONSEQ or SEQ transfer with hready high
   assign accessTaken = hsel && htrans[1] && hready;

   // Read value chosen in the address phase; unmapped reads give zero
   always_comb begin
      readValue = 32'h0;
      if (haddr == CTRL_ADDR) begin
         readValue[CTRL_HOLD_DIS_BIT] = holdDisable;
         readValue[CTRL_RETAIN_BIT] = burstEightRetain;
      end else if (haddr == STATUS_ADDR) begin
         readValue[STAT_GRANT_BIT] = ~busGrantN;
         readValue[STAT_RELEASED_BIT] = memBusOeN;
         readValue[STAT_REQ_BIT] = ~reqSyncN;
         readValue[STAT_PENDING_BIT] = ~pendingClear;
         readValue[STAT_DRAIN_BIT] = (state_reg == ST_DRAIN);
      end
   end

   // Capture the address phase; zero wait, always OKAY
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         apWrite_reg <= 1'b0;
         apAddr_reg <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready) begin
            apWrite_reg <= accessTaken && hwrite;
            apAddr_reg <= haddr;
            if (accessTaken && !hwrite) begin
               hrdata <= readValue;
            end
         end
      end
   end

   // Control register written in the data phase; size is ignored
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_reg <= CTRL_RESET;
      end else if (apWrite_reg && apAddr_reg == CTRL_ADDR) begin
         ctrl_reg[CTRL_HOLD_DIS_BIT] <= hwdata[CTRL_HOLD_DIS_BIT];
         ctrl_reg[CTRL_RETAIN_BIT] <= hwdata[CTRL_RETAIN_BIT];
      end
   end

endmodule // ebh_top

//--- ebh_top_asserts.sv
// Checker for the bus hold handshake and the reset pin states
`timescale 1ns/1ns
module ebh_top_asserts
   import ebh_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic busRequestN,
   input wire logic busGrantN,
   input wire logic memBusOeN,
   input wire logic extDataBusOeN,
   input wire logic irqAckOut,
   input wire logic [3:0] irqNumberOut,
   input wire logic [3:0] dmaEventOut,
   input wire logic powerdownOut,
   input wire logic timerOutA,
   input wire logic timerOutB,
   input wire logic hostInterruptOut,
   input wire logic hostReadyN,
   input wire logic hostSelectN,
   input wire logic hostDataBusOeN,
   input wire logic [9:0] serialPinsOeN
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Request and pin changes both show one edge late, so windows keep the cycle counts unshifted
   sequence s_grant_back;
      !busGrantN [*4] ##[1:4] busGrantN;
   endsequence
   sequence s_redrive;
      memBusOeN [*3] ##[1:4] !memBusOeN;
   endsequence

   a_hiz_not_early: assert property (
      $fell(busRequestN) && busGrantN && !memBusOeN |-> !memBusOeN [*4])
      else $error("memory pins released too early");
   a_grant_after_hiz: assert property (
      $rose(memBusOeN) && !busRequestN |-> ##[1:2] !busGrantN)
      else $error("grant late after pin release");
   a_grant_return: assert property (
      $rose(busRequestN) && !busGrantN |-> s_grant_back)
      else $error("grant return outside its window");
   a_redrive_window: assert property (
      $rose(busRequestN) && !busGrantN && memBusOeN |-> s_redrive)
      else $error("pins driven again outside window");
   a_grant_released: assert property (
      !busGrantN |-> memBusOeN && extDataBusOeN)
      else $error("grant while memory pins driven");
   a_grant_holds: assert property (
      !busGrantN && !busRequestN |=> !busGrantN)
      else $error("grant dropped while request low");
   a_reset_levels: assert property (
      $rose(reset_n) |-> !irqAckOut && irqNumberOut == 4'h0 &&
      dmaEventOut == 4'h0 && !powerdownOut && !timerOutA && !timerOutB &&
      hostInterruptOut)
      else $error("low or high group wrong in reset");
   a_reset_hiz: assert property (
      $rose(reset_n) |-> memBusOeN && extDataBusOeN && hostDataBusOeN &&
      serialPinsOeN == 10'h3ff ##1 !memBusOeN)
      else $error("high impedance group wrong in reset");
   a_ready_gated: assert property (
      $rose(reset_n) |-> hostReadyN == !$past(hostSelectN))
      else $error("host ready not gated by select");
endmodule // ebh_top_asserts

bind ebh_top ebh_top_asserts ebh_top_asserts_inst (.clk, .reset_n,
   .busRequestN, .busGrantN, .memBusOeN, .extDataBusOeN, .irqAckOut,
   .irqNumberOut, .dmaEventOut, .powerdownOut, .timerOutA, .timerOutB,
   .hostInterruptOut, .hostReadyN, .hostSelectN, .hostDataBusOeN,
   .serialPinsOeN);

//--- ebh_hold_master.sv
// Outside bus master and system reset source for the hold handshake
`timescale 1ns/1ns
module ebh_hold_master
   import ebh_pkg::*;
(
   input wire logic clk,
   input wire logic rstReq,
   input wire logic want,
   input wire logic [7:0] holdLen,
   input wire logic busGrantN,
   output logic busRequestN,
   output logic reset_n
);
   logic [4:0] rstCnt;
   logic [7:0] heldCnt;
   logic reqLow;
   logic done;

   // Single-rate clock here, so no lock wait is ever owed
   // Reset stays low a full minimum width after the last request
   always_ff @(posedge clk) begin
      if (rstReq) begin
         rstCnt <= 5'(RESET_MIN_CYC);
      end else if (rstCnt != 5'h0) begin
         rstCnt <= rstCnt - 5'h1;
      end
   end
   assign reset_n = !rstReq && (rstCnt == 5'h0);

   // Request once, keep it low through the grant, then let go
   always_ff @(posedge clk) begin
      if (!reset_n || !want) begin
         reqLow <= 1'b0;
         heldCnt <= 8'h0;
         done <= 1'b0;
      end else if (!reqLow && busGrantN && !done) begin
         reqLow <= 1'b1;
      end else if (!busGrantN && !done) begin
         heldCnt <= heldCnt + 8'h1;
         if (heldCnt == holdLen) begin
            reqLow <= 1'b0;
            done <= 1'b1;
         end
      end
   end
   // Idle high before the first edge too
   assign busRequestN = !(reqLow === 1'b1);
endmodule // ebh_hold_master

//--- ebh_top_tb_top.sv
// Self-checking bench for the bus hold and reset pin block
`timescale 1ns/1ns
module ebh_top_tb_top
   import ebh_pkg::*;
;
   logic clk, reset_n, hsel, hwrite, hreadyout, hresp, rstReq, want;
   logic memXferBusy, asyncAccessActive, asyncReadyIn, sdramAccess;
   logic hostSelectN, busRequestN, busGrantN, memBusOeN, extDataBusOeN;
   logic irqAckOut, powerdownOut, timerOutA, timerOutB;
   logic hostInterruptOut, hostReadyN, hostDataBusOeN, holdPending;
   logic [3:0] chipEnableN, byteEnableN;
   logic [9:0] memStrobeN, serialPinsOut;
   logic [15:0] hostDataBusOut;
   logic [19:0] extAddrBus;
   logic [31:0] extDataBusOut, memReadData;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] irqNumberOut, dmaEventOut;
   logic [7:0] haddr, holdLen;
   logic [9:0] serialPinsOeN;
   logic [31:0] hwdata, hrdata, pat, rd;
   int miscompares, nCompared;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ebh_top ebh_top_inst (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
      .busRequestN, .busGrantN, .memXferBusy, .asyncAccessActive,
      .asyncReadyIn, .sdramAccess, .ctlDataOut(pat), .ctlDataOeN(pat[5]),
      .ctlAddr(pat[19:0]), .ctlChipEnableN(pat[3:0]),
      .ctlByteEnableN(pat[7:4]), .ctlStrobeN(pat[9:0]), .holdPending,
      .memReadData, .extDataBusIn(~pat), .extDataBusOut,
      .extDataBusOeN, .extAddrBus, .chipEnableN, .byteEnableN,
      .memStrobeN, .memBusOeN, .irqAckIn(pat[1]),
      .irqNumberIn(pat[7:4]), .dmaEventIn(pat[11:8]),
      .powerdownIn(pat[2]), .timerAIn(pat[3]), .timerBIn(pat[4]),
      .hostInterruptIn(pat[5]), .hostReadyInN(pat[6]), .hostSelectN,
      .hostDataOutIn(pat[31:16]), .hostDataOeInN(pat[7]),
      .serialPinsIn(pat[25:16]), .serialOeInN(pat[9:0]), .irqAckOut,
      .irqNumberOut, .dmaEventOut, .powerdownOut, .timerOutA, .timerOutB,
      .hostInterruptOut, .hostReadyN, .hostDataBusOut, .hostDataBusOeN,
      .serialPinsOut, .serialPinsOeN);

   ebh_hold_master ebh_hold_master_inst (.clk, .rstReq, .want, .holdLen,
      .busGrantN, .busRequestN, .reset_n);

   // Compare and count
   task check(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task test_done;
      $display("Compared %0d, mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One single-word transfer; read data is taken at the closing edge
   task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   function automatic logic sig(input int w);
      return (w == 0) ? busRequestN : (w == 1) ? memBusOeN : busGrantN;
   endfunction

   // Edges until a handshake signal is sampled at a level, capped at 60
   task waitfor(input int w, input logic lvl, output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sig(w) !== lvl && n < 60);
   endtask

   task regs;
      ahb(1'b0, CTRL_ADDR, 32'h0);
      check(rd[1:0], CTRL_RESET);
      check(hresp, 1'b0);
      ahb(1'b1, CTRL_ADDR, 32'h3);
      ahb(1'b0, CTRL_ADDR, 32'h0);
      check(rd[1:0], 2'h3);
      ahb(1'b1, 8'h10, 32'hffffffff);
      ahb(1'b0, 8'h10, 32'h0);
      check(rd, 32'h0);
      ahb(1'b1, CTRL_ADDR, 32'h0);
   endtask

   task reset_pins;
      hostSelectN <= 1'b0;
      rstReq <= 1'b1;
      tick(1);
      rstReq <= 1'b0;
      tick(3);
      check({irqAckOut, irqNumberOut, dmaEventOut, powerdownOut, timerOutA,
         timerOutB}, 32'h0);
      check(hostInterruptOut, 1'b1);
      check({memBusOeN, extDataBusOeN, hostDataBusOeN, serialPinsOeN},
         13'h1fff);
      check(hostReadyN, 1'b1);
      hostSelectN <= 1'b1;
      tick(2);
      check(hostReadyN, 1'b0);
      do @(posedge clk); while (reset_n !== 1'b1);
      check(hostInterruptOut, 1'b1);
      tick(2);
      check({irqNumberOut, hostInterruptOut}, {pat[7:4], pat[5]});
      check({memBusOeN, extDataBusOeN}, 2'h0);
      check(extDataBusOut, pat);
      check(memReadData, ~pat);
      check({extAddrBus, memStrobeN}, {pat[19:0], pat[9:0]});
      check({hostDataBusOut, chipEnableN, byteEnableN},
         {pat[31:16], pat[3:0], pat[7:4]});
      check(serialPinsOut, pat[25:16]);
   endtask

   task hold_basic;
      int n, g, d;
      holdLen <= 8'h06;
      want <= 1'b1;
      waitfor(0, 1'b0, n);
      waitfor(1, 1'b1, n);
      check(n >= HIZ_MIN_CYC, 1'b1);
      waitfor(2, 1'b0, n);
      check(n <= GRANT_LOW_MAX_CYC, 1'b1);
      check({memBusOeN, extDataBusOeN}, 2'h3);
      while (busRequestN === 1'b0) begin
         check({busGrantN, memBusOeN, holdPending}, 3'h3);
         @(posedge clk);
      end
      g = 0;
      d = 0;
      for (int i = 1; i <= 10; i++) begin
         @(posedge clk);
         if (g == 0 && busGrantN === 1'b1) g = i;
         if (d == 0 && memBusOeN === 1'b0) d = i;
      end
      check(g >= GRANT_HIGH_MIN_CYC && g <= GRANT_HIGH_MAX_CYC,
         1'b1);
      check(d >= DRIVE_MIN_CYC && d <= DRIVE_MAX_CYC, 1'b1);
      check(holdPending, 1'b0);
      want <= 1'b0;
      tick(2);
   endtask

   // Busy transfer, stretched async access, retained SDRAM run
   task hold_pending;
      int n;
      for (int k = 0; k < 3; k++) begin
         if (k == 2) ahb(1'b1, CTRL_ADDR, 32'h1 << CTRL_RETAIN_BIT);
         memXferBusy <= (k == 0);
         asyncAccessActive <= (k == 1);
         asyncReadyIn <= (k != 1);
         sdramAccess <= (k == 2);
         want <= 1'b1;
         waitfor(0, 1'b0, n);
         waitfor(1, 1'b1, n);
         // The run is seen one edge before the request, so the last
         // retained access ends one edge short of the run length
         check(n >= ((k == 2) ? int'(BURST_RETAIN_LEN) - 1 : 60),
            1'b1);
         memXferBusy <= 1'b0;
         asyncAccessActive <= 1'b0;
         asyncReadyIn <= 1'b1;
         sdramAccess <= 1'b0;
         waitfor(2, 1'b0, n);
         check({busGrantN, memBusOeN}, 2'h1);
         want <= 1'b0;
         waitfor(2, 1'b1, n);
         ahb(1'b1, CTRL_ADDR, 32'h0);
      end
   endtask

   // Disabled hold never grants, and a withdrawn request stays ungranted
   task hold_disable;
      int n;
      ahb(1'b1, CTRL_ADDR, 32'h1 << CTRL_HOLD_DIS_BIT);
      want <= 1'b1;
      waitfor(2, 1'b0, n);
      check(busGrantN, 1'b1);
      ahb(1'b0, STATUS_ADDR, 32'h0);
      check(rd[STAT_GRANT_BIT], 1'b0);
      want <= 1'b0;
      tick(8);
      check({busGrantN, memBusOeN}, 2'h2);
      ahb(1'b1, CTRL_ADDR, 32'h0);
   endtask

   initial begin
      rstReq = 1'b1;
      want = 1'b0;
      holdLen = 8'h04;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      memXferBusy = 1'b0;
      asyncAccessActive = 1'b0;
      asyncReadyIn = 1'b1;
      sdramAccess = 1'b0;
      hostSelectN = 1'b1;
      pat = 32'hffffffdf;
      miscompares = 0;
      nCompared = 0;
      tick(8);
      rstReq <= 1'b0;
      do @(posedge clk); while (reset_n !== 1'b1);
      tick(1);
      regs;
      reset_pins;
      hold_basic;
      hold_pending;
      hold_disable;
      test_done;
   end

   // Whole run needs a few hundred cycles; cut a hang well beyond that
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
endmodule // ebh_top_tb_top
